// ===== design/aux_ctrl.sv
// Auxiliary control register with software reset and dual data pointers
`timescale 1ns/1ps
module aux_ctrl
    import aux_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        clkEn,
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [7:0]  regRdData,
    input  wire logic        opPtrInc,
    input  wire logic        opPtrLoad,
    input  wire logic [15:0] ptrLoadValue,
    input  wire logic        opAuxInc,
    input  wire logic        opJump,
    input  wire logic        opCodeRead,
    input  wire logic        opDataRead,
    input  wire logic        opDataWrite,
    input  wire logic [7:0]  accValue,
    output logic      [15:0] memAddr,
    output mem_kind_e        memKind,
    output logic             memValid,
    output logic             cfgSelect,
    input  wire logic        keypadEvent,
    input  wire logic        powerFailReset,
    output logic             brownoutOff,
    output logic             brownoutIrqSelect,
    output logic             lowVoltEpromMode,
    output logic             chipResetOut,
    output logic             irq
);
    ptr_bank_if ptrBus ();

    logic                 softRst;
    logic                 pointerSelect;
    logic                 keypadIrqFlag;
    logic                 auxWrite;
    logic [7:0]           auxWrValue;
    logic [7:0]           auxView;
    logic                 anyMemOp;
    logic                 dataOp;
    logic                 moveMiss;
    logic [IRQ_WIDTH-1:0] irqStatus;
    logic [IRQ_WIDTH-1:0] irqMask;
    logic [IRQ_WIDTH-1:0] irqEvents;
    logic [7:0]           next_rdData;

    function automatic logic addrHit(input logic [7:0] a, input logic [7:0] target);
        return a == target;
    endfunction

    function automatic logic inCfgSpace(input logic [15:0] a);
        return (a >= CFG_FIRST) && (a <= CFG_LAST);
    endfunction

    // Software reset request and its stretched chip reset
    soft_reset_seq u_reset (
        .clk     (clk),
        .sys_rst (sys_rst),
        .clkEn   (clkEn),
        .trigger (auxWrite && auxWrValue[BIT_SOFT_RESET] && !softRst),
        .chipRst (softRst)
    );

    assign chipResetOut = softRst;

    // Pointer bank
    data_pointer_bank u_bank (
        .clk     (clk),
        .sys_rst (sys_rst),
        .clkEn   (clkEn),
        .bus     (ptrBus.bank)
    );

    assign ptrBus.sel       = pointerSelect;
    assign ptrBus.clear     = softRst;
    assign ptrBus.wrLow     = regWr && addrHit(regAddr, ADDR_PTR_LOW) && !softRst;
    assign ptrBus.wrHigh    = regWr && addrHit(regAddr, ADDR_PTR_HIGH) && !softRst;
    assign ptrBus.wrByte    = regWrData;
    assign ptrBus.inc       = opPtrInc && !softRst;
    assign ptrBus.load      = opPtrLoad && !softRst;
    assign ptrBus.loadValue = ptrLoadValue;

    // Register view: bits 3, 2 and 1 always read zero
    assign auxView = {keypadIrqFlag, brownoutOff, brownoutIrqSelect, lowVoltEpromMode,
                      1'b0, 1'b0, 1'b0, pointerSelect};

    // Bus write has priority over an in-place increment
    assign auxWrite   = !softRst && ((regWr && addrHit(regAddr, ADDR_AUX_CONTROL)) || opAuxInc);
    assign auxWrValue = (regWr && addrHit(regAddr, ADDR_AUX_CONTROL)) ? regWrData
                                                                      : auxView + 8'h01;

    // Plain control bits, cleared by chip reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pointerSelect     <= AUX_RESET[BIT_SELECT];
            brownoutOff       <= AUX_RESET[BIT_BO_OFF];
            brownoutIrqSelect <= AUX_RESET[BIT_BO_IRQ_SEL];
        end else if (clkEn) begin
            if (softRst) begin
                pointerSelect     <= AUX_RESET[BIT_SELECT];
                brownoutOff       <= AUX_RESET[BIT_BO_OFF];
                brownoutIrqSelect <= AUX_RESET[BIT_BO_IRQ_SEL];
            end else if (auxWrite) begin
                pointerSelect     <= auxWrValue[BIT_SELECT];
                brownoutOff       <= auxWrValue[BIT_BO_OFF];
                brownoutIrqSelect <= auxWrValue[BIT_BO_IRQ_SEL];
            end
        end
    end

    // Low-voltage mode survives soft reset; only sys_rst and powerFailReset clear it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lowVoltEpromMode <= AUX_RESET[BIT_LOW_VOLT];
        end else if (clkEn) begin
            if (powerFailReset) begin
                lowVoltEpromMode <= 1'b0;
            end else if (auxWrite && auxWrValue[BIT_LOW_VOLT]) begin
                lowVoltEpromMode <= 1'b1;
            end
        end
    end

    // Keypad flag: hardware set wins over a software clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            keypadIrqFlag <= AUX_RESET[BIT_KEYPAD];
        end else if (clkEn) begin
            if (softRst) begin
                keypadIrqFlag <= AUX_RESET[BIT_KEYPAD];
            end else if (keypadEvent) begin
                keypadIrqFlag <= 1'b1;
            end else if (auxWrite && !auxWrValue[BIT_KEYPAD]) begin
                keypadIrqFlag <= 1'b0;
            end
        end
    end

    // Memory address generation through the selected pointer
    assign anyMemOp = (opJump || opCodeRead || opDataRead || opDataWrite) && !softRst;
    assign dataOp   = (opDataRead || opDataWrite) && !softRst;
    assign moveMiss = dataOp && !inCfgSpace(ptrBus.curPtr);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            memAddr   <= RESTART_ADDR;
            memKind   <= MEM_JUMP;
            memValid  <= 1'b0;
            cfgSelect <= 1'b0;
        end else if (clkEn) begin
            memValid  <= anyMemOp;
            cfgSelect <= dataOp && inCfgSpace(ptrBus.curPtr);
            if (opJump || opCodeRead) begin
                memAddr <= ptrBus.curPtr + {8'h00, accValue};
                memKind <= opJump ? MEM_JUMP : MEM_CODE;
            end else if (dataOp) begin
                memAddr <= ptrBus.curPtr;
                memKind <= opDataRead ? MEM_DATA_RD : MEM_DATA_WR;
            end
        end
    end

    // Interrupt status, write one to clear, set wins
    assign irqEvents = {moveMiss, ptrBus.incWrap, keypadEvent && !softRst};

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irqStatus <= IRQ_RESET;
            irqMask   <= IRQ_RESET;
        end else if (clkEn) begin
            if (softRst) begin
                irqStatus <= IRQ_RESET;
                irqMask   <= IRQ_RESET;
            end else begin
                if (regWr && addrHit(regAddr, ADDR_IRQ_STATUS)) begin
                    irqStatus <= (irqStatus & ~regWrData[IRQ_WIDTH-1:0]) | irqEvents;
                end else begin
                    irqStatus <= irqStatus | irqEvents;
                end
                if (regWr && addrHit(regAddr, ADDR_IRQ_MASK)) begin
                    irqMask <= regWrData[IRQ_WIDTH-1:0];
                end
            end
        end
    end

    assign irq = |(irqStatus & irqMask);

    // Read data, valid only in the cycle after the strobe
    always_comb begin
        next_rdData = 8'h00;
        if (addrHit(regAddr, ADDR_AUX_CONTROL)) begin
            next_rdData = auxView;
        end else if (addrHit(regAddr, ADDR_PTR_LOW)) begin
            next_rdData = ptrBus.curPtr[7:0];
        end else if (addrHit(regAddr, ADDR_PTR_HIGH)) begin
            next_rdData = ptrBus.curPtr[15:8];
        end else if (addrHit(regAddr, ADDR_IRQ_STATUS)) begin
            next_rdData = {5'h00, irqStatus};
        end else if (addrHit(regAddr, ADDR_IRQ_MASK)) begin
            next_rdData = {5'h00, irqMask};
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            regRdData <= 8'h00;
        end else if (clkEn) begin
            regRdData <= regRd ? next_rdData : 8'h00;
        end
    end

    // Checks
    default clocking cb @(posedge clk iff clkEn);
    endclocking
    default disable iff (sys_rst);

    property p_soft_reset_starts;
        regWr && addrHit(regAddr, ADDR_AUX_CONTROL) && regWrData[BIT_SOFT_RESET] && !softRst
            |=> chipResetOut [*2];
    endproperty
    a_soft_reset_starts: assert property (p_soft_reset_starts) else $error("no soft reset");

    property p_reset_clears;
        chipResetOut |=> pointerSelect == 1'b0 && brownoutOff == 1'b0 && irqStatus == IRQ_RESET
            && ptrBus.curPtr == PTR_RESET;
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("registers not cleared");

    property p_bit_reads_zero;
        regRd && addrHit(regAddr, ADDR_AUX_CONTROL) |=> regRdData[BIT_WIRED_ZERO] == 1'b0
            && regRdData[BIT_SOFT_RESET] == 1'b0;
    endproperty
    a_bit_reads_zero: assert property (p_bit_reads_zero) else $error("bit 2 reads one");

    property p_select_write;
        regWr && addrHit(regAddr, ADDR_AUX_CONTROL) && !softRst
            |=> pointerSelect == $past(regWrData[BIT_SELECT]);
    endproperty
    a_select_write: assert property (p_select_write) else $error("select not written");

    property p_increment;
        opPtrInc && !opPtrLoad && !softRst && !auxWrite
            |=> ptrBus.curPtr == $past(ptrBus.curPtr) + 16'h0001;
    endproperty
    a_increment: assert property (p_increment) else $error("pointer not incremented");

    property p_load;
        opPtrLoad && !softRst && !auxWrite |=> ptrBus.curPtr == $past(ptrLoadValue);
    endproperty
    a_load: assert property (p_load) else $error("pointer not loaded");

    property p_low_byte;
        ptrBus.wrLow && !opPtrInc && !opPtrLoad && !auxWrite
            |=> ptrBus.curPtr[7:0] == $past(regWrData);
    endproperty
    a_low_byte: assert property (p_low_byte) else $error("low byte not written");

    property p_code_addr;
        opCodeRead && !opJump && !softRst
            |=> memValid && memKind == MEM_CODE
                && memAddr == $past(ptrBus.curPtr) + {8'h00, $past(accValue)};
    endproperty
    a_code_addr: assert property (p_code_addr) else $error("code address wrong");

    property p_aux_inc;
        opAuxInc && !regWr && !softRst
            |=> pointerSelect != $past(pointerSelect) && brownoutOff == $past(brownoutOff)
                && keypadIrqFlag == ($past(keypadIrqFlag) || $past(keypadEvent));
    endproperty
    a_aux_inc: assert property (p_aux_inc) else $error("increment disturbed bits");

    property p_low_volt_sticky;
        lowVoltEpromMode && !powerFailReset |=> lowVoltEpromMode;
    endproperty
    a_low_volt_sticky: assert property (p_low_volt_sticky) else $error("mode lost");

    property p_keypad_set;
        keypadEvent && !softRst
            |=> keypadIrqFlag ##1 (keypadIrqFlag || $past(auxWrite) || $past(softRst));
    endproperty
    a_keypad_set: assert property (p_keypad_set) else $error("keypad flag not set");

    property p_move_outside;
        dataOp && !inCfgSpace(ptrBus.curPtr) |=> !cfgSelect && irqStatus[IRQ_MOVE_MISS];
    endproperty
    a_move_outside: assert property (p_move_outside) else $error("move left config");

    property p_brownout_bit;
        regWr && addrHit(regAddr, ADDR_AUX_CONTROL) && !softRst
            |=> brownoutOff == $past(regWrData[BIT_BO_OFF]);
    endproperty
    a_brownout_bit: assert property (p_brownout_bit) else $error("brownout bit wrong");

    property p_high_byte;
        ptrBus.wrHigh && !opPtrInc && !opPtrLoad && !auxWrite
            |=> ptrBus.curPtr[15:8] == $past(regWrData);
    endproperty
    a_high_byte: assert property (p_high_byte) else $error("high byte not written");

    property p_jump_addr;
        opJump && !softRst |=> memValid && memKind == MEM_JUMP
            && memAddr == $past(ptrBus.curPtr) + {8'h00, $past(accValue)};
    endproperty
    a_jump_addr: assert property (p_jump_addr) else $error("jump address wrong");

    property p_data_addr;
        opDataRead && !opJump && !opCodeRead && !softRst
            |=> memValid && memKind == MEM_DATA_RD && memAddr == $past(ptrBus.curPtr);
    endproperty
    a_data_addr: assert property (p_data_addr) else $error("data address wrong");

    property p_cfg_hit;
        dataOp && inCfgSpace(ptrBus.curPtr) |=> cfgSelect;
    endproperty
    a_cfg_hit: assert property (p_cfg_hit) else $error("config byte not selected");

    property p_keypad_clear;
        regWr && addrHit(regAddr, ADDR_AUX_CONTROL) && !regWrData[BIT_KEYPAD] && !keypadEvent
            && !softRst |=> !keypadIrqFlag;
    endproperty
    a_keypad_clear: assert property (p_keypad_clear) else $error("keypad not cleared");

    property p_low_volt_clear;
        powerFailReset |=> !lowVoltEpromMode;
    endproperty
    a_low_volt_clear: assert property (p_low_volt_clear) else $error("mode not cleared");

    c_soft_reset: cover property (chipResetOut ##1 !chipResetOut);
    c_switch_inc: cover property (opAuxInc ##1 opPtrInc);
    c_cfg_hit: cover property (cfgSelect);
    c_irq: cover property (irq);
endmodule

// ===== design/aux_pkg.sv
// Constants and types shared by the auxiliary control block
package aux_pkg;
    localparam logic [7:0]  ADDR_AUX_CONTROL = 8'h00;
    localparam logic [7:0]  ADDR_PTR_LOW     = 8'h01;
    localparam logic [7:0]  ADDR_PTR_HIGH    = 8'h02;
    localparam logic [7:0]  ADDR_IRQ_STATUS  = 8'h03;
    localparam logic [7:0]  ADDR_IRQ_MASK    = 8'h04;
    localparam int          BIT_SELECT       = 0;
    localparam int          BIT_RESERVED     = 1;
    localparam int          BIT_WIRED_ZERO   = 2;
    localparam int          BIT_SOFT_RESET   = 3;
    localparam int          BIT_LOW_VOLT     = 4;
    localparam int          BIT_BO_IRQ_SEL   = 5;
    localparam int          BIT_BO_OFF       = 6;
    localparam int          BIT_KEYPAD       = 7;
    localparam logic [7:0]  AUX_RESET        = 8'h00;
    localparam logic [15:0] PTR_RESET        = 16'h0000;
    localparam logic [15:0] RESTART_ADDR     = 16'h0000;
    localparam int          PTR_COUNT        = 2;
    localparam int          IRQ_KEYPAD       = 0;
    localparam int          IRQ_PTR_WRAP     = 1;
    localparam int          IRQ_MOVE_MISS    = 2;
    localparam int          IRQ_WIDTH        = 3;
    localparam logic [2:0]  IRQ_RESET        = 3'h0;
    localparam logic [15:0] CFG_FIRST        = 16'hfd00;
    localparam logic [15:0] CFG_LAST         = 16'hfd01;
    localparam int          CLK_PERIOD_NS    = 25;
    localparam int          SOFT_RST_NS      = 1000;
    localparam int          SOFT_RST_CYCLES  = (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0]  SOFT_RST_LAST    = 8'(SOFT_RST_CYCLES - 1);
    typedef enum logic [1:0] {MEM_JUMP, MEM_CODE, MEM_DATA_RD, MEM_DATA_WR} mem_kind_e;
endpackage

// ===== design/data_pointer_bank.sv
// Two data pointers; only the selected one is seen or changed, but clear resets both
`timescale 1ns/1ps
module data_pointer_bank
    import aux_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    ptr_bank_if.bank bus
);
    logic [15:0] ptrs [PTR_COUNT];

    for (genvar i = 0; i < PTR_COUNT; i++) begin : g_ptr
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                ptrs[i] <= PTR_RESET;
            end else if (clkEn) begin
                if (bus.clear) begin
                    ptrs[i] <= PTR_RESET;
                end else if (bus.sel == 1'(i)) begin
                    if (bus.load) begin
                        ptrs[i] <= bus.loadValue;
                    end else if (bus.inc) begin
                        ptrs[i] <= ptrs[i] + 16'h0001;
                    end else begin
                        if (bus.wrLow) begin
                            ptrs[i][7:0] <= bus.wrByte;
                        end
                        if (bus.wrHigh) begin
                            ptrs[i][15:8] <= bus.wrByte;
                        end
                    end
                end
            end
        end
    end

    assign bus.curPtr  = ptrs[bus.sel];
    assign bus.incWrap = bus.inc && !bus.load && (ptrs[bus.sel] == 16'hffff);

    default clocking cb @(posedge clk iff clkEn);
    endclocking
    default disable iff (sys_rst);

    property p_unselected_hold;
        !bus.clear |=> ptrs[!$past(bus.sel)] == $past(ptrs[!bus.sel]);
    endproperty
    a_unselected_hold: assert property (p_unselected_hold) else $error("unselected pointer moved");
endmodule

// ===== design/ptr_bank_if.sv
// Control and result signals between the register logic and the pointer bank
`timescale 1ns/1ps
interface ptr_bank_if;
    logic        sel;
    logic        clear;
    logic        wrLow;
    logic        wrHigh;
    logic [7:0]  wrByte;
    logic        inc;
    logic        load;
    logic [15:0] loadValue;
    logic [15:0] curPtr;
    logic        incWrap;
    modport ctrl (output sel, clear, wrLow, wrHigh, wrByte, inc, load, loadValue,
                  input curPtr, incWrap);
    modport bank (input sel, clear, wrLow, wrHigh, wrByte, inc, load, loadValue,
                  output curPtr, incWrap);
endinterface

// ===== design/soft_reset_seq.sv
// Stretches a software reset request into a chip reset of fixed length
`timescale 1ns/1ps
module soft_reset_seq
    import aux_pkg::*;
(
    input wire logic  clk,
    input wire logic  sys_rst,
    input wire logic  clkEn,
    input wire logic  trigger,
    output logic      chipRst
);
    typedef enum logic {RUN, HOLD} seq_state_e;
    localparam int HOLD_LEN = SOFT_RST_CYCLES;

    seq_state_e state;
    logic [7:0] holdCount;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state     <= RUN;
            holdCount <= 8'h00;
        end else if (clkEn) begin
            case (state)
                RUN: begin
                    if (trigger) begin
                        state     <= HOLD;
                        holdCount <= SOFT_RST_LAST;
                    end
                end
                HOLD: begin
                    if (holdCount == 8'h00) begin
                        state <= RUN;
                    end else begin
                        holdCount <= holdCount - 8'h01;
                    end
                end
                default: state <= RUN;
            endcase
        end
    end

    assign chipRst = (state == HOLD);

    default clocking cb @(posedge clk iff clkEn);
    endclocking
    default disable iff (sys_rst);

    property p_hold_length;
        $rose(chipRst) |-> ##[HOLD_LEN:HOLD_LEN] !chipRst;
    endproperty
    a_hold_length: assert property (p_hold_length) else $error("reset hold length wrong");
endmodule

// ===== dv/core_model.sv
// Processor core side: register bus master and instruction pulses
`timescale 1ns/1ps
module core_model (
    input  wire logic        clk,
    input  wire logic [7:0]  regRdData,
    output logic      [7:0]  regAddr,
    output logic      [7:0]  regWrData,
    output logic             regWr,
    output logic             regRd,
    output logic      [6:0]  ops,
    output logic      [7:0]  accValue,
    output logic      [15:0] ptrLoadValue
);
    initial begin
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        ops = 7'h00;
        accValue = 8'h00;
        ptrLoadValue = 16'h0000;
    end

    // Released lines show the inverse of their last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        regAddr <= ~a;
        @(negedge clk);
        d = regRdData;
    endtask

    // Bit order: inc, load, aux inc, jump, code read, data read, data write
    task automatic op(input int k, input logic [7:0] acc, input logic [15:0] lv);
        @(posedge clk);
        ops <= 7'(1 << k);
        accValue <= acc;
        ptrLoadValue <= lv;
        @(posedge clk);
        ops <= 7'h00;
        accValue <= ~acc;
        ptrLoadValue <= ~lv;
        @(negedge clk);
    endtask
endmodule

// ===== dv/testbench.sv
// Self-checking testbench of the auxiliary control block
`timescale 1ns/1ps
module testbench;
    import aux_pkg::*;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        keypadEvent = 1'b0;
    logic        powerFailReset = 1'b0;
    logic        clkEn = 1'b1;
    wire  [7:0]  regAddr, regWrData, regRdData, accValue;
    wire  [6:0]  ops;
    wire  [15:0] ptrLoadValue, memAddr;
    wire         regWr, regRd, memValid, cfgSelect, brownoutOff, brownoutIrqSelect;
    wire         lowVoltEpromMode, chipResetOut, irq;
    mem_kind_e   memKind;
    int          n_errors = 0;
    int          n_compared = 0;
    int          n;
    logic [15:0] ptr [2] = '{16'h0000, 16'h0000};
    logic [15:0] lfsr = 16'h0048;
    logic [15:0] e;
    logic [7:0]  aux = 8'h00;
    logic [7:0]  d;
    logic [2:0]  st = 3'h0;
    logic [2:0]  mk = 3'h0;

    initial begin
        forever #12.5 clk = ~clk;
    end

    aux_ctrl dut (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .opPtrInc(ops[0]), .opPtrLoad(ops[1]), .ptrLoadValue(ptrLoadValue),
        .opAuxInc(ops[2]), .opJump(ops[3]), .opCodeRead(ops[4]), .opDataRead(ops[5]),
        .opDataWrite(ops[6]), .accValue(accValue), .memAddr(memAddr), .memKind(memKind),
        .memValid(memValid), .cfgSelect(cfgSelect), .keypadEvent(keypadEvent),
        .powerFailReset(powerFailReset), .brownoutOff(brownoutOff),
        .brownoutIrqSelect(brownoutIrqSelect), .lowVoltEpromMode(lowVoltEpromMode),
        .chipResetOut(chipResetOut), .irq(irq));
    core_model cm (.clk(clk), .regRdData(regRdData), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .ops(ops), .accValue(accValue),
        .ptrLoadValue(ptrLoadValue));

    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] x);
        cm.rd(a, d);
        chk(16'(d), 16'(x));
    endtask

    task automatic irqchk();
        @(negedge clk);
        chk(16'(irq), 16'(|(st & mk)));
    endtask

    // Aux write: keypad flag only clears, low-volt bit only sets, bits 3..1 read 0
    task automatic auxupd(input logic [7:0] v);
        aux = (aux & v & 8'h80) | (v & 8'h61) | ((aux | v) & 8'h10);
    endtask

    task automatic ptrchk();
        rdchk(ADDR_PTR_LOW, ptr[aux[0]][7:0]);
        rdchk(ADDR_PTR_HIGH, ptr[aux[0]][15:8]);
    endtask

    task automatic pop(input int k, input logic [15:0] lv);
        cm.op(k, 8'h00, lv);
        if (k == 1) ptr[aux[0]] = lv;
        if (k == 0) begin
            if (ptr[aux[0]] == 16'hffff) st[IRQ_PTR_WRAP] = 1'b1;
            ptr[aux[0]] = ptr[aux[0]] + 16'h0001;
        end
        if (k == 2) auxupd(aux + 8'h01);
    endtask

    task automatic memop(input int k, input logic [7:0] acc);
        cm.op(k, acc, 16'h0000);
        e = (k < 5) ? ptr[aux[0]] + 16'(acc) : ptr[aux[0]];
        chk(16'(memValid), 16'h0001);
        chk(memAddr, e);
        chk(16'(memKind), 16'(k - 3));
        chk(16'(cfgSelect), 16'(k > 4 && e >= CFG_FIRST && e <= CFG_LAST));
        if (k > 4 && !(e >= CFG_FIRST && e <= CFG_LAST)) st[IRQ_MOVE_MISS] = 1'b1;
    endtask

    initial begin
        #(25 * 20000);
        n_errors++;
        end_sim();
    end

    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        for (int a = 0; a < 6; a++) rdchk(8'(a), 8'h00);
        $display("test reset values done");
        cm.wr(ADDR_AUX_CONTROL, 8'hf7);
        auxupd(8'hf7);
        rdchk(ADDR_AUX_CONTROL, aux);
        chk(16'({brownoutOff, brownoutIrqSelect, lowVoltEpromMode}), 16'h0007);
        $display("test aux bits done");
        for (int i = 0; i < 2; i++) begin
            e = rnd();
            cm.wr(ADDR_PTR_LOW, e[7:0]);
            cm.wr(ADDR_PTR_HIGH, e[15:8]);
            ptr[aux[0]] = e;
            pop(2, 16'h0000);
            rdchk(ADDR_AUX_CONTROL, aux);
        end
        ptrchk();
        pop(1, rnd());
        pop(0, 16'h0000);
        ptrchk();
        pop(2, 16'h0000);
        ptrchk();
        pop(1, 16'hffff);
        pop(0, 16'h0000);
        ptrchk();
        rdchk(ADDR_IRQ_STATUS, 8'(st));
        $display("test pointers done");
        irqchk();
        cm.wr(ADDR_IRQ_MASK, 8'h07);
        mk = 3'h7;
        irqchk();
        cm.wr(ADDR_IRQ_STATUS, 8'h02);
        st[IRQ_PTR_WRAP] = 1'b0;
        irqchk();
        pop(1, CFG_FIRST);
        for (int k = 3; k < 7; k++) memop(k, 8'(rnd()));
        pop(1, rnd());
        memop(6, 8'h00);
        rdchk(ADDR_IRQ_STATUS, 8'(st));
        irqchk();
        $display("test memory ops done");
        @(posedge clk);
        keypadEvent <= 1'b1;
        @(posedge clk);
        keypadEvent <= 1'b0;
        aux[7] = 1'b1;
        st[IRQ_KEYPAD] = 1'b1;
        rdchk(ADDR_AUX_CONTROL, aux);
        cm.wr(ADDR_AUX_CONTROL, aux | 8'h80);
        rdchk(ADDR_AUX_CONTROL, aux);
        cm.wr(ADDR_AUX_CONTROL, aux & 8'h7f);
        auxupd(aux & 8'h7f);
        rdchk(ADDR_AUX_CONTROL, aux);
        rdchk(ADDR_IRQ_STATUS, 8'(st));
        $display("test keypad done");
        cm.wr(ADDR_AUX_CONTROL, aux | 8'h08);
        n = 0;
        for (int i = 0; i < 100; i++) begin
            @(negedge clk);
            if (chipResetOut === 1'b1) n++;
            else if (n > 0) break;
        end
        chk(16'(n), 16'(SOFT_RST_CYCLES));
        aux &= 8'h10;
        ptr = '{16'h0000, 16'h0000};
        st = 3'h0;
        mk = 3'h0;
        rdchk(ADDR_AUX_CONTROL, aux);
        for (int a = 1; a < 5; a++) rdchk(8'(a), 8'h00);
        chk(16'(lowVoltEpromMode), 16'h0001);
        irqchk();
        @(posedge clk);
        powerFailReset <= 1'b1;
        @(posedge clk);
        powerFailReset <= 1'b0;
        @(negedge clk);
        chk(16'(lowVoltEpromMode), 16'h0000);
        $display("test resets done");
        @(posedge clk);
        clkEn <= 1'b0;
        cm.wr(ADDR_PTR_LOW, 8'h5a);
        cm.wr(ADDR_AUX_CONTROL, 8'h08);
        clkEn <= 1'b1;
        ptrchk();
        chk(16'(chipResetOut), 16'h0000);
        $display("test clock enable done");
        end_sim();
    end
endmodule
